/* File: hw/rtc_top.sv */
// Serial target, resets, power gating, side-band access and port protection of the repeater
//
// Contract
// [RQ1] Any reset leaves bus pins undriven
// [RQ2] All resets clear config; pin sync untouched
// [RQ3] Leave reset in the stored repeater role
// [RQ4] Serial port on except OFF; deep standby
// [RQ5] Sleep/detach: line sense only; speed gating
// [RQ6] Move between L1, L2 and active
// [RQ7] Side-band reaches customer registers; type selectable
// [RQ8] System avoids simultaneous same-register access
// [RQ9] Side-band accepted anytime while registers accessible
// [RQ10] Overvoltage disables USB2 path while present
// [RQ11] Host recovers link after overvoltage
// [RQ12] Charging source bit; connect clears it
// [RQ13] Charging source allowed in either role
// [RQ14] Target only; answers in every mode; code ignores the bus in PM_OFF
// [RQ15] Never stretch clock; tolerate others
// [RQ16] Ignore general call and 10-bit
// [RQ17] Acknowledge every offset byte
// [RQ18] Pointer increments per byte
// [RQ19] Pointer wraps FF to 00 only
// [RQ20] Undefined: ack, read FF, write ignored
// [RQ21] Repeated START begins new transaction
// [RQ22] Address fixed bits plus strap bits
// [RQ23] Strap sampled once after power-on
// [RQ24] Write lands after eight data bits
// [RQ25] Reset pin active low
// [RQ26] Bus lines synchronised and filtered
`timescale 1ns/1ps

module rtc_top #(
  parameter int NUM_CFG = 6
) (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic ext_rst_n_i,
  input wire logic supply_ok_i,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  input wire logic [1:0] addr_strap_i,
  input wire logic [1:0] otp_role_i,
  input wire logic deep_standby_i,
  input wire logic attach_fs_i,
  input wire logic attach_hs_i,
  input wire logic detach_i,
  input wire logic enter_l1_i,
  input wire logic enter_l2_i,
  input wire logic resume_i,
  input wire logic ovp_dp_i,
  input wire logic ovp_dn_i,
  input wire logic usb_connect_i,
  input wire logic rap_valid_i,
  input wire logic rap_write_i,
  input wire logic [7:0] rap_addr_i,
  input wire logic [7:0] rap_wdata_i,
  output logic [7:0] rap_rdata_o,
  output logic rap_done_o,
  output rtc_pkg::rtc_pmode_e power_mode_o,
  output logic i2c_pwr_o,
  output logic fsls_fe_en_o,
  output logic hs_fe_en_o,
  output logic single_ended_line_sense_en_o,
  output logic usb2_path_en_o,
  output logic charging_port_source_en_o,
  output logic [1:0] repeater_role_o,
  output logic [NUM_CFG*8-1:0] cfg_o
);
  import rtc_pkg::*;

  typedef struct packed {
    logic [SY_W-1:0] sync1;
    logic [SY_W-1:0] sync2;
    logic [1:0] flt;
    logic [1:0] flt_d;
    logic [1:0][1:0] fcnt;
    logic [1:0] strap_cnt;
    logic strap_done;
    logic [1:0] addr_sel;
    rtc_tstate_e st;
    logic [3:0] bitcnt;
    logic [7:0] shreg;
    logic rw;
    logic m_ack;
    logic [7:0] ptr;
    logic sda_oe;
    logic sda_lo;
    logic [7:0] ctrl;
    logic [NUM_CFG-1:0][7:0] cfg;
    rtc_pmode_e pmode;
    logic hs_last;
    logic [1:0] role;
    logic conn_d;
    logic [7:0] rap_rdata;
    logic rap_done;
    logic i2c_pwr;
    logic fs_en;
    logic hs_en;
    logic se_en;
    logic usb2_en;
    logic cdp_src;
  } rtc_state_s;

  rtc_state_s r_reg;
  rtc_state_s r_next;

  logic scl_rise;
  logic scl_fall;
  logic start_c;
  logic stop_c;
  logic in_reset;
  logic [6:0] taddr;
  logic ovp_now;
  logic connected;

  ////////////////////////////////////////////////////////////////////////////////
  // Register access helpers, shared by the serial port and the side-band path

  // Read one byte; side-band sees status and customer registers, not control
  function automatic logic [7:0] reg_rd(input rtc_state_s s, input logic [7:0] a,
                                        input logic register_access_message);
    logic [7:0] idx;
    idx = a - OFS_CFG_BASE;
    if (a == OFS_CTRL && !register_access_message) begin
      reg_rd = s.ctrl;
    end else if (a == OFS_STATUS) begin
      reg_rd = {1'b0, s.role, s.pmode, s.conn_d, s.usb2_en ? 1'b0 : 1'b1};
    end else if (a >= OFS_CFG_BASE && idx < 8'(NUM_CFG)) begin
      reg_rd = s.cfg[idx];
    end else begin
      reg_rd = UNDEF_RD; // [RQ20] [RQ7]
    end
  endfunction

  // Write one byte; status, undefined and protected targets drop the data
  function automatic rtc_state_s reg_wr(input rtc_state_s s, input logic [7:0] a,
                                        input logic [7:0] d, input logic register_access_message);
    logic [7:0] idx;
    reg_wr = s;
    idx = a - OFS_CFG_BASE;
    if (a == OFS_CTRL && !register_access_message) begin
      reg_wr.ctrl = d; // [RQ13]
    end else if (a >= OFS_CFG_BASE && idx < 8'(NUM_CFG)) begin
      if (!(register_access_message && s.ctrl[CTRL_RAP_RO_BIT])) begin
        reg_wr.cfg[idx] = d; // [RQ7]
      end
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Bus events from the filtered lines

  // Start and stop need SCL high on both samples so a data edge never aliases
  assign scl_rise = r_reg.flt[0] & ~r_reg.flt_d[0];
  assign scl_fall = ~r_reg.flt[0] & r_reg.flt_d[0];
  assign start_c = r_reg.flt_d[1] & ~r_reg.flt[1] & r_reg.flt[0] & r_reg.flt_d[0];
  assign stop_c = ~r_reg.flt_d[1] & r_reg.flt[1] & r_reg.flt[0] & r_reg.flt_d[0];
  assign in_reset = ~r_reg.sync2[SY_EXTRST] | r_reg.ctrl[CTRL_SWRST_BIT]; // [RQ25] [RQ2]
  assign taddr = {TADDR_HI, r_reg.addr_sel, TADDR_LO}; // [RQ22]
  assign ovp_now = r_reg.sync2[SY_OVPDP] | r_reg.sync2[SY_OVPDN];
  assign connected = r_reg.sync2[SY_CONN];

  ////////////////////////////////////////////////////////////////////////////////
  // Next state of the whole block

  always_comb begin
    r_next = r_reg;
    r_next.rap_done = 1'b0;
    r_next.sda_lo = 1'b0;
    // Pin synchronisers; only power-on reset touches them
    r_next.sync1 = {addr_strap_i, usb_connect_i, ovp_dn_i, ovp_dp_i, supply_ok_i,
                    ext_rst_n_i, sda_i, scl_i}; // [RQ2]
    r_next.sync2 = r_reg.sync1;
    // Spike filter: a new level must persist before it is believed
    for (int i = 0; i < 2; i++) begin
      if (r_reg.sync2[i] != r_reg.flt[i]) begin
        if (r_reg.fcnt[i] == FILT_LAST) begin
          r_next.flt[i] = r_reg.sync2[i]; // [RQ26]
          r_next.fcnt[i] = 2'h0;
        end else begin
          r_next.fcnt[i] = r_reg.fcnt[i] + 2'h1;
        end
      end else begin
        r_next.fcnt[i] = 2'h0;
      end
    end
    r_next.flt_d = r_reg.flt;

    // Strap is caught once, after the synchroniser has filled
    if (!r_reg.strap_done) begin
      if (r_reg.strap_cnt == STRAP_WAIT) begin
        r_next.addr_sel = r_reg.sync2[SY_STRAP +: 2]; // [RQ23]
        r_next.strap_done = 1'b1;
      end else begin
        r_next.strap_cnt = r_reg.strap_cnt + 2'h1;
      end
    end

    // Serial target; SCL is only ever an input, so the clock is never held
    if (in_reset || r_reg.pmode == PM_OFF) begin
      r_next.st = TS_IDLE;
      r_next.sda_oe = 1'b0; // [RQ1]
    end else if (start_c) begin
      r_next.st = TS_ADDR; // [RQ21]
      r_next.bitcnt = 4'h0;
      r_next.sda_oe = 1'b0;
    end else if (stop_c) begin
      r_next.st = TS_IDLE;
      r_next.sda_oe = 1'b0;
    end else begin
      case (r_reg.st)
        TS_ADDR, TS_OFFS, TS_WDATA: begin
          if (scl_rise) begin
            r_next.shreg = {r_reg.shreg[6:0], r_reg.flt[1]}; // [RQ15]
            r_next.bitcnt = r_reg.bitcnt + 4'h1;
          end else if (scl_fall && r_reg.bitcnt == BITS_LAST) begin
            r_next.bitcnt = 4'h0;
            if (r_reg.st == TS_ADDR) begin
              // General call and 10-bit prefixes never equal the fixed address
              if (r_reg.shreg[7:1] == taddr) begin // [RQ16] [RQ14]
                r_next.rw = r_reg.shreg[0];
                r_next.st = TS_ACK_ADDR;
                r_next.sda_oe = 1'b1;
              end else begin
                r_next.st = TS_IDLE;
              end
            end else if (r_reg.st == TS_OFFS) begin
              r_next.ptr = r_reg.shreg;
              r_next.st = TS_ACK_OFFS;
              r_next.sda_oe = 1'b1; // [RQ17]
            end else begin
              r_next = reg_wr(r_next, r_reg.ptr, r_reg.shreg, 1'b0); // [RQ24] [RQ20]
              r_next.ptr = r_reg.ptr + 8'h01; // [RQ18] [RQ19]
              r_next.st = TS_ACK_W;
              r_next.sda_oe = 1'b1;
            end
          end
        end
        TS_ACK_ADDR, TS_ACK_OFFS, TS_ACK_W: begin
          if (scl_fall) begin
            r_next.bitcnt = 4'h0;
            if (r_reg.st == TS_ACK_ADDR && r_reg.rw) begin
              r_next.shreg = reg_rd(r_reg, r_reg.ptr, 1'b0);
              r_next.sda_oe = ~r_next.shreg[7];
              r_next.ptr = r_reg.ptr + 8'h01; // [RQ18] [RQ19]
              r_next.st = TS_RDATA;
            end else begin
              r_next.sda_oe = 1'b0;
              r_next.st = (r_reg.st == TS_ACK_ADDR) ? TS_OFFS : TS_WDATA;
            end
          end
        end
        TS_RDATA: begin
          if (scl_rise) begin
            r_next.bitcnt = r_reg.bitcnt + 4'h1;
          end else if (scl_fall) begin
            if (r_reg.bitcnt == BITS_LAST) begin
              r_next.sda_oe = 1'b0;
              r_next.st = TS_ACK_R;
            end else begin
              r_next.shreg = {r_reg.shreg[6:0], 1'b0};
              r_next.sda_oe = ~r_reg.shreg[6];
            end
          end
        end
        TS_ACK_R: begin
          if (scl_rise) begin
            r_next.m_ack = ~r_reg.flt[1];
          end else if (scl_fall) begin
            r_next.bitcnt = 4'h0;
            if (r_reg.m_ack) begin
              r_next.shreg = reg_rd(r_reg, r_reg.ptr, 1'b0);
              r_next.sda_oe = ~r_next.shreg[7];
              r_next.ptr = r_reg.ptr + 8'h01; // [RQ18] [RQ19]
              r_next.st = TS_RDATA;
            end else begin
              r_next.st = TS_IDLE;
            end
          end
        end
        default: begin
          r_next.st = TS_IDLE;
          r_next.sda_oe = 1'b0;
        end
      endcase
    end

    // Side-band access; applied after the serial port, no arbitration
    if (rap_valid_i && !in_reset && r_reg.pmode != PM_OFF) begin // [RQ9] [RQ8]
      r_next.rap_done = 1'b1;
      r_next.rap_rdata = reg_rd(r_reg, rap_addr_i, 1'b1); // [RQ7]
      if (rap_write_i) begin
        r_next = reg_wr(r_next, rap_addr_i, rap_wdata_i, 1'b1); // [RQ7]
      end
    end

    // Connect edge switches the charging source off; it beats a write
    r_next.conn_d = connected;
    if (connected && !r_reg.conn_d) begin
      r_next.ctrl[CTRL_CDP_BIT] = 1'b0; // [RQ12]
    end

    // Power mode sequencing from link events
    if (!r_reg.sync2[SY_SUPPLY]) begin
      r_next.pmode = PM_OFF; // [RQ14]
    end else begin
      case (r_reg.pmode)
        PM_OFF: r_next.pmode = PM_DETACH;
        PM_DEEP: begin
          if (resume_i || attach_fs_i || attach_hs_i) begin
            r_next.pmode = PM_DETACH;
          end
        end
        PM_DETACH: begin
          if (attach_hs_i) begin
            r_next.pmode = PM_ACT_HS;
          end else if (attach_fs_i) begin
            r_next.pmode = PM_ACT_FS;
          end else if (deep_standby_i) begin
            r_next.pmode = PM_DEEP;
          end
        end
        PM_ACT_FS, PM_ACT_HS: begin
          r_next.hs_last = (r_reg.pmode == PM_ACT_HS);
          if (detach_i) begin
            r_next.pmode = PM_DETACH;
          end else if (enter_l1_i) begin
            r_next.pmode = PM_L1; // [RQ6]
          end else if (enter_l2_i) begin
            r_next.pmode = PM_L2; // [RQ6]
          end else if (attach_hs_i) begin
            r_next.pmode = PM_ACT_HS;
          end
        end
        PM_L1, PM_L2: begin
          if (detach_i) begin
            r_next.pmode = PM_DETACH;
          end else if (resume_i) begin
            r_next.pmode = r_reg.hs_last ? PM_ACT_HS : PM_ACT_FS; // [RQ6]
          end
        end
        default: r_next.pmode = PM_OFF;
      endcase
    end

    // Any reset: config cleared, role reloaded from the stored setting
    if (in_reset) begin
      r_next.ctrl = CTRL_RST; // [RQ2]
      for (int k = 0; k < NUM_CFG; k++) begin
        r_next.cfg[k] = CFG_RST; // [RQ2]
      end
      r_next.role = otp_role_i; // [RQ3]
      r_next.pmode = r_reg.sync2[SY_SUPPLY] ? PM_DETACH : PM_OFF;
    end

    // Front-end enables follow the mode being entered
    r_next.i2c_pwr = (r_next.pmode != PM_OFF); // [RQ4]
    r_next.fs_en = (r_next.pmode == PM_ACT_FS); // [RQ5] [RQ4]
    r_next.hs_en = (r_next.pmode == PM_ACT_HS); // [RQ5] [RQ4]
    r_next.se_en = (r_next.pmode == PM_DETACH) || (r_next.pmode == PM_L1) ||
                   (r_next.pmode == PM_L2) || (r_next.pmode == PM_ACT_FS); // [RQ5]
    // Path comes back by itself; the link itself needs host recovery
    r_next.usb2_en = ~ovp_now; // [RQ10]
    r_next.cdp_src = r_next.ctrl[CTRL_CDP_BIT] & ~connected; // [RQ12] [RQ13]
  end

  ////////////////////////////////////////////////////////////////////////////////
  // State register; power-on reset loads constants only

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      r_reg <= '0;
      r_reg.sync1 <= SYNC_RST;
      r_reg.sync2 <= SYNC_RST;
      r_reg.flt <= FLT_RST;
      r_reg.flt_d <= FLT_RST;
    end else begin
      r_reg <= r_next;
    end
  end

  // Outputs, all from the state register
  assign sda_o = r_reg.sda_lo;
  assign sda_oe_o = r_reg.sda_oe;
  assign rap_rdata_o = r_reg.rap_rdata;
  assign rap_done_o = r_reg.rap_done;
  assign power_mode_o = r_reg.pmode;
  assign i2c_pwr_o = r_reg.i2c_pwr;
  assign fsls_fe_en_o = r_reg.fs_en;
  assign hs_fe_en_o = r_reg.hs_en;
  assign single_ended_line_sense_en_o = r_reg.se_en;
  assign usb2_path_en_o = r_reg.usb2_en;
  assign charging_port_source_en_o = r_reg.cdp_src;
  assign repeater_role_o = r_reg.role;
  assign cfg_o = r_reg.cfg;

endmodule

/* File: hw/rtc_pkg.sv */
// Shared constants, encodings and register layout of the repeater target control block
package rtc_pkg;

  // Byte width of the register file and the bus shifter
  localparam int BYTE_W = 8;

  // Power modes, Gray coded along detach -> active -> sleep
  typedef enum logic [2:0] {
    PM_OFF    = 3'h0,
    PM_DEEP   = 3'h1,
    PM_DETACH = 3'h3,
    PM_ACT_FS = 3'h2,
    PM_ACT_HS = 3'h6,
    PM_L1     = 3'h7,
    PM_L2     = 3'h5
  } rtc_pmode_e;

  // Serial target states, Gray coded along a write then a read
  typedef enum logic [3:0] {
    TS_IDLE     = 4'h0,
    TS_ADDR     = 4'h1,
    TS_ACK_ADDR = 4'h3,
    TS_OFFS     = 4'h2,
    TS_ACK_OFFS = 4'h6,
    TS_WDATA    = 4'h7,
    TS_ACK_W    = 4'h5,
    TS_RDATA    = 4'h4,
    TS_ACK_R    = 4'hC
  } rtc_tstate_e;

  // Register offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h01;
  localparam logic [7:0] OFS_CFG_BASE = 8'h02;

  // Control register fields
  localparam int CTRL_SWRST_BIT = 0;
  localparam int CTRL_CDP_BIT = 1;
  localparam int CTRL_RAP_RO_BIT = 2;

  // Reset and fill values
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] CFG_RST = 8'h00;
  localparam logic [7:0] UNDEF_RD = 8'hFF;

  // Fixed parts of the 7-bit target address around the strap bits
  localparam logic [2:0] TADDR_HI = 3'h4;
  localparam logic [1:0] TADDR_LO = 2'h3;

  // Synchroniser lane positions
  localparam int SY_SCL = 0;
  localparam int SY_SDA = 1;
  localparam int SY_EXTRST = 2;
  localparam int SY_SUPPLY = 3;
  localparam int SY_OVPDP = 4;
  localparam int SY_OVPDN = 5;
  localparam int SY_CONN = 6;
  localparam int SY_STRAP = 7;
  localparam int SY_W = 9;
  localparam logic [8:0] SYNC_RST = 9'h003;
  localparam logic [1:0] FLT_RST = 2'h3;

  // Timing: spike filter on the bus lines and strap settle delay
  localparam int CLK_NS = 40;
  localparam int FILT_NS = 50;
  localparam int FILT_CYC = (FILT_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [1:0] FILT_LAST = 2'(FILT_CYC - 1);
  localparam logic [1:0] STRAP_WAIT = 2'h3;
  localparam logic [3:0] BITS_LAST = 4'h8;

endpackage

/* File: bench/rtc_i2c_master.sv */
// Bus controller model: drives the serial clock and pulls the data line low
`timescale 1ns/1ps
module rtc_i2c_master #(
  parameter int QTR = 5
) (
  input wire logic clk_i,
  input wire logic sda_i,
  output logic scl_o,
  output logic sda_low_o
);
  ////////////////////////////////////////////////////////////////////////
  // Bus idles released; the clock is never held back, so nothing here stretches
  initial begin
    scl_o = 1'b1;
    sda_low_o = 1'b0;
  end

  task automatic gap(input int n);
    repeat (n) @(posedge clk_i);
  endtask

  // START or repeated START; data moves a quarter after each clock fall
  task automatic start();
    gap(QTR);
    sda_low_o <= 1'b0;
    gap(2 * QTR);
    scl_o <= 1'b1;
    gap(QTR);
    sda_low_o <= 1'b1;
    gap(QTR);
    scl_o <= 1'b0;
  endtask

  // One bit out and the line level sampled mid-high
  task automatic bit_io(input logic b, output logic s);
    gap(QTR);
    sda_low_o <= !b;
    gap(QTR);
    scl_o <= 1'b1;
    gap(QTR);
    s = sda_i;
    gap(QTR);
    scl_o <= 1'b0;
  endtask

  // Eight bits MSB first, then the acknowledge slot
  task automatic xfer(input logic [7:0] d, input logic ack_in, output logic [7:0] q,
                      output logic ack);
    for (int i = 7; i >= 0; i--) bit_io(d[i], q[i]);
    bit_io(ack_in, ack);
  endtask

  task automatic stop();
    gap(QTR);
    sda_low_o <= 1'b1;
    gap(QTR);
    scl_o <= 1'b1;
    gap(2 * QTR);
    sda_low_o <= 1'b0;
    gap(2 * QTR);
  endtask
endmodule

/* File: bench/rtc_top_asserts.sv */
// Port-level assertions of the repeater target control block
`timescale 1ns/1ps
module rtc_top_asserts #(
  parameter int NUM_CFG = 6
) (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic ext_rst_n_i,
  input wire logic sda_oe_o,
  input wire logic [1:0] otp_role_i,
  input wire logic rap_valid_i,
  input wire logic ovp_dp_i,
  input wire logic ovp_dn_i,
  input wire logic usb_connect_i,
  input wire logic rap_done_o,
  input wire rtc_pkg::rtc_pmode_e power_mode_o,
  input wire logic i2c_pwr_o,
  input wire logic fsls_fe_en_o,
  input wire logic hs_fe_en_o,
  input wire logic single_ended_line_sense_en_o,
  input wire logic usb2_path_en_o,
  input wire logic charging_port_source_en_o,
  input wire logic [1:0] repeater_role_o,
  input wire logic [NUM_CFG*8-1:0] cfg_o
);
  import rtc_pkg::*;
  ////////////////////////////////////////////////////////////////////////
  // Pin reset needs a few cycles to pass its synchroniser
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);
  quiet_in_reset_a: assert property (!ext_rst_n_i [*5] |-> !sda_oe_o)
    else $error("data line driven in pin reset");
  cfg_clear_a: assert property (!ext_rst_n_i [*5] |-> cfg_o == '0)
    else $error("config not cleared by pin reset");
  role_reload_a: assert property (!ext_rst_n_i [*5] |-> repeater_role_o == otp_role_i)
    else $error("role not reloaded");
  // Power gating follows the mode
  port_power_a: assert property (i2c_pwr_o == (power_mode_o != PM_OFF))
    else $error("serial port power wrong");
  deep_gate_a: assert property (power_mode_o == PM_DEEP |-> !fsls_fe_en_o && !hs_fe_en_o)
    else $error("front end on in deep standby");
  sleep_gate_a: assert property (power_mode_o inside {PM_DETACH, PM_L1, PM_L2} |->
    single_ended_line_sense_en_o && !fsls_fe_en_o && !hs_fe_en_o)
    else $error("sleep gating wrong");
  speed_gate_a: assert property ((hs_fe_en_o == (power_mode_o == PM_ACT_HS)) &&
    (fsls_fe_en_o == (power_mode_o == PM_ACT_FS)))
    else $error("speed gating wrong");
  // Side-band answers exactly one cycle after an accepted request
  side_answer_a: assert property (rap_valid_i && ext_rst_n_i && power_mode_o != PM_OFF
    |=> rap_done_o)
    else $error("side-band request not answered");
  answer_cause_a: assert property (rap_done_o |-> $past(rap_valid_i))
    else $error("answer without request");
  ovp_cut_a: assert property ((ovp_dp_i || ovp_dn_i) [*5] |-> !usb2_path_en_o)
    else $error("path on during overvoltage");
  connect_off_a: assert property (usb_connect_i [*5] |-> !charging_port_source_en_o)
    else $error("charging source on while connected");
  cover property (power_mode_o == PM_L2);
  cover property (rap_done_o);
  cover property ($fell(usb2_path_en_o));
endmodule

bind rtc_top rtc_top_asserts #(.NUM_CFG(NUM_CFG)) rtc_top_asserts_inst (.*);

/* File: bench/repeater_i2c_target_ctrl_test.sv */
// Self-checking bench of the repeater target control block
`timescale 1ns/1ps
module repeater_i2c_target_ctrl_test;
  import rtc_pkg::*;
  logic clk_sys_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic ext_rst_n_i = 1'b1;
  logic [1:0] strap = 2'h0;
  logic [1:0] role = 2'h1;
  logic [6:0] ev = '0;
  logic ovp_dp = 1'b0, ovp_dn = 1'b0, conn = 1'b0, rv = 1'b0, rw = 1'b0;
  logic [7:0] ra = '0, rwd = '0, v, rrd;
  logic scl, sda_low, sda_oe, sda_o, sda_bus, done, i2c_pwr, fsls, hs, se, path, charging_port_source;
  logic [47:0] cfg;
  logic [1:0] role_o;
  logic [6:0] adr;
  logic [23:0] dat;
  rtc_pmode_e mode;
  int fail_count = 0, checked = 0;
  // Event order {deep, fs, hs, detach, l1, l2, resume} and resulting modes
  logic [6:0] evs [9] = '{7'h10, 7'h04, 7'h01, 7'h02, 7'h01, 7'h08, 7'h20, 7'h08, 7'h40};
  rtc_pmode_e mds [9] = '{PM_ACT_HS, PM_L1, PM_ACT_HS, PM_L2, PM_ACT_HS, PM_DETACH,
                          PM_ACT_FS, PM_DETACH, PM_DEEP};

  always #20 clk_sys_i = ~clk_sys_i;
  // Open-drain data line with pull-up
  assign sda_bus = !(sda_low || (sda_oe && !sda_o));

  rtc_i2c_master rtc_i2c_master_inst (.clk_i(clk_sys_i), .sda_i(sda_bus), .scl_o(scl),
    .sda_low_o(sda_low));
  rtc_top #(.NUM_CFG(6)) rtc_top_inst (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
    .ext_rst_n_i(ext_rst_n_i), .supply_ok_i(1'b1), .scl_i(scl), .sda_i(sda_bus),
    .sda_o(sda_o), .sda_oe_o(sda_oe), .addr_strap_i(strap), .otp_role_i(role),
    .deep_standby_i(ev[6]), .attach_fs_i(ev[5]), .attach_hs_i(ev[4]), .detach_i(ev[3]),
    .enter_l1_i(ev[2]), .enter_l2_i(ev[1]), .resume_i(ev[0]), .ovp_dp_i(ovp_dp),
    .ovp_dn_i(ovp_dn), .usb_connect_i(conn), .rap_valid_i(rv), .rap_write_i(rw),
    .rap_addr_i(ra), .rap_wdata_i(rwd), .rap_rdata_o(rrd), .rap_done_o(done),
    .power_mode_o(mode), .i2c_pwr_o(i2c_pwr), .fsls_fe_en_o(fsls), .hs_fe_en_o(hs),
    .single_ended_line_sense_en_o(se), .usb2_path_en_o(path),
    .charging_port_source_en_o(charging_port_source), .repeater_role_o(role_o), .cfg_o(cfg));

  ////////////////////////////////////////////////////////////////////////
  task automatic test_done();
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic chk_val(input logic [47:0] got, input logic [47:0] exp);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_flag(input logic got, input logic exp);
    chk_val({47'h0, got}, {47'h0, exp});
  endtask
  // Inputs move on rising edges; outputs are looked at on falling ones or several cycles after a rising one
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys_i);
  endtask
  function automatic logic [3:0] en_of(input rtc_pmode_e m);
    return {m != PM_OFF, m == PM_ACT_FS, m == PM_ACT_HS,
            m inside {PM_DETACH, PM_L1, PM_L2, PM_ACT_FS}};
  endfunction
  task automatic wbyte(input logic [7:0] d, input logic ack);
    logic [7:0] q;
    logic a;
    rtc_i2c_master_inst.xfer(d, 1'b1, q, a);
    chk_flag(!a, ack);
  endtask
  task automatic i2c_wr(input logic [7:0] ofs, input int n, input logic [23:0] d);
    rtc_i2c_master_inst.start();
    wbyte({adr, 1'b0}, 1'b1);
    wbyte(ofs, 1'b1);
    for (int i = 0; i < n; i++) wbyte(d[8*i +: 8], 1'b1);
    rtc_i2c_master_inst.stop();
  endtask
  // Offset write, repeated START, then reads with a final refusal
  task automatic i2c_rd(input logic [7:0] ofs, input int n, input logic [23:0] exp);
    logic [7:0] q;
    logic a;
    rtc_i2c_master_inst.start();
    wbyte({adr, 1'b0}, 1'b1);
    wbyte(ofs, 1'b1);
    rtc_i2c_master_inst.start();
    wbyte({adr, 1'b1}, 1'b1);
    for (int i = 0; i < n; i++) begin
      rtc_i2c_master_inst.xfer(8'hFF, i == n - 1, q, a);
      chk_val(q, exp[8*i +: 8]);
    end
    rtc_i2c_master_inst.stop();
  endtask
  // Side-band access; never overlaps serial traffic to the same place
  task automatic sb(input logic w, input logic [7:0] a, input logic [7:0] d,
                    input logic [7:0] exp);
    rv <= 1'b1;
    rw <= w;
    ra <= a;
    rwd <= d;
    tick(1);
    rv <= 1'b0;
    @(negedge clk_sys_i);
    chk_flag(done, 1'b1);
    if (!w) chk_val(rrd, exp);
    tick(1);
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Hang guard
  initial begin
    tick(90000);
    fail_count++;
    test_done();
  end

  initial begin
    v = 8'($urandom(21956));
    strap = v[1:0];
    adr = {3'h4, v[1:0], 2'h3};
    tick(8);
    rst_n_i <= 1'b1;
    tick(20);
    strap <= ~strap;
    for (int i = 0; i < 9; i++) begin
      ev <= evs[i];
      tick(1);
      ev <= '0;
      tick(2);
      @(negedge clk_sys_i);
      chk_val(mode, mds[i]);
      chk_val({i2c_pwr, fsls, hs, se}, en_of(mds[i]));
      tick(1);
    end
    chk_val(role_o, 2'h1);
    $display("link modes done");
    dat = 24'($urandom);
    i2c_wr(OFS_CFG_BASE, 3, dat);
    i2c_wr(8'hFF, 2, {8'h02, 8'h5A});
    foreach (evs[i]) if (i < 3) begin
      rtc_i2c_master_inst.start();
      wbyte({i == 0 ? 7'h00 : (i == 1 ? 7'h7A : adr ^ 7'h08), 1'b0}, 1'b0);
      wbyte(8'h06, 1'b0);
      rtc_i2c_master_inst.stop();
    end
    @(negedge clk_sys_i);
    chk_val(cfg, {24'h0, dat});
    chk_flag(charging_port_source, 1'b1);
    tick(1);
    conn <= 1'b1;
    tick(8);
    chk_flag(charging_port_source, 1'b0);
    i2c_rd(8'hFE, 3, 24'h00FFFF);
    conn <= 1'b0;
    $display("serial done");
    v = 8'($urandom);
    sb(1'b1, 8'h05, v, 8'h00);
    sb(1'b0, 8'h05, 8'h00, v);
    sb(1'b0, OFS_CTRL, 8'h00, 8'hFF);
    sb(1'b0, OFS_STATUS, 8'h00, {1'b0, 2'h1, PM_DEEP, 2'b00});
    i2c_wr(OFS_CTRL, 1, 24'h4);
    sb(1'b1, 8'h05, ~v, 8'h00);
    sb(1'b0, 8'h05, 8'h00, v);
    i2c_wr(OFS_CTRL, 1, 24'h0);
    // Software reset: the reset it starts releases the line before the ack is sampled
    rtc_i2c_master_inst.start();
    wbyte({adr, 1'b0}, 1'b1);
    wbyte(OFS_CTRL, 1'b1);
    wbyte(8'h01, 1'b0);
    rtc_i2c_master_inst.stop();
    chk_val(cfg, 48'h0);
    i2c_wr(OFS_CFG_BASE, 1, dat);
    $display("side-band done");
    for (int k = 0; k < 2; k++) begin
      ovp_dp <= k == 0;
      ovp_dn <= k == 1;
      tick(8);
      chk_flag(path, 1'b0);
      ovp_dp <= 1'b0;
      ovp_dn <= 1'b0;
      tick(8);
      chk_flag(path, 1'b1);
    end
    $display("overvoltage done");
    // Port reset as the host's recovery path
    role <= 2'h2;
    ext_rst_n_i <= 1'b0;
    tick(8);
    chk_val(cfg, 48'h0);
    chk_val(role_o, 2'h2);
    ext_rst_n_i <= 1'b1;
    tick(10);
    chk_val(mode, PM_DETACH);
    i2c_rd(OFS_CFG_BASE, 1, 24'h0);
    $display("pin reset done");
    test_done();
  end
endmodule
